// *** aec_pkg.sv ***
// Package of constants and types for the auto exposure controller
package aec_pkg;
  localparam int unsigned AEC_CLK_HZ = 20000000;
  // Register map (word addresses on the plain register port)
  localparam logic [4:0] AEC_REG_CTRL = 5'h00;
  localparam logic [4:0] AEC_REG_EXP_MIN = 5'h01;
  localparam logic [4:0] AEC_REG_EXP_MAX = 5'h02;
  localparam logic [4:0] AEC_REG_GAIN_MIN = 5'h03;
  localparam logic [4:0] AEC_REG_GAIN_MAX = 5'h04;
  localparam logic [4:0] AEC_REG_TGT = 5'h05;
  localparam logic [4:0] AEC_REG_TGT_MIN = 5'h06;
  localparam logic [4:0] AEC_REG_TGT_MAX = 5'h07;
  localparam logic [4:0] AEC_REG_DAMP = 5'h08;
  localparam logic [4:0] AEC_REG_PRIO_EXP = 5'h09;
  localparam logic [4:0] AEC_REG_BIAS = 5'h0a;
  localparam logic [4:0] AEC_REG_ROI_X = 5'h0b;
  localparam logic [4:0] AEC_REG_ROI_Y = 5'h0c;
  localparam logic [4:0] AEC_REG_ROI_W = 5'h0d;
  localparam logic [4:0] AEC_REG_ROI_H = 5'h0e;
  localparam logic [4:0] AEC_REG_EXP = 5'h10;
  localparam logic [4:0] AEC_REG_GAIN = 5'h11;
  localparam logic [4:0] AEC_REG_MEAS = 5'h12;
  localparam logic [4:0] AEC_REG_STAT = 5'h13;
  localparam int AEC_NREGS = 32;
  // Control register fields
  localparam int AEC_F_EXPMODE = 0;
  localparam int AEC_F_GAINMODE = 2;
  localparam int AEC_F_TGTMAN = 4;
  localparam int AEC_F_LIGHT = 5;
  localparam int AEC_F_METER = 7;
  localparam int AEC_F_PRIO = 9;
  localparam int AEC_F_ROIEN = 10;
  localparam logic [31:0] AEC_CTRL_RST = 32'h0000_0000;
  // Reset values
  localparam logic [23:0] AEC_EXP_MIN_RST = 24'h00_0001;
  localparam logic [23:0] AEC_EXP_MAX_RST = 24'hff_ffff;
  localparam logic [7:0] AEC_GAIN_MIN_RST = 8'h00;
  localparam logic [7:0] AEC_GAIN_MAX_RST = 8'hff;
  localparam logic [6:0] AEC_TGT_RST = 7'h32;
  localparam logic [6:0] AEC_TGT_MIN_RST = 7'h00;
  localparam logic [6:0] AEC_TGT_MAX_RST = 7'h64;
  localparam logic [6:0] AEC_PCT_FULL = 7'h64;
  // Damping in 1/256 units: 0x100 = 1.0, 0x80 = 0.5
  localparam logic [8:0] AEC_DAMP_ONE = 9'h100;
  localparam logic [8:0] AEC_DAMP_RST = 9'h080;
  // Exposure priority start time in microseconds
  localparam int unsigned AEC_PRIO_EXP_US = 5000;
  localparam logic [23:0] AEC_PRIO_EXP_RST = 24'(AEC_PRIO_EXP_US);
  // Bias in thirds of a stop, signed, -9..9
  localparam logic signed [4:0] AEC_BIAS_MIN = -5'sd9;
  localparam logic signed [4:0] AEC_BIAS_MAX = 5'sd9;
  // Automatic targets in percent for each lighting and metering choice
  localparam logic [6:0] AEC_TGT_AUTO_NORM = 7'h32;
  localparam logic [6:0] AEC_TGT_AUTO_BACK = 7'h3c;
  localparam logic [6:0] AEC_TGT_AUTO_FRONT = 7'h28;
  localparam logic [6:0] AEC_TGT_AUTO_SPOT = 7'h2d;
  // Central window sizes as fraction divisors: spot ~3% (w/6 x h/6), partial ~11% (w/3 x h/3)
  localparam int AEC_SPOT_DIV = 6;
  localparam int AEC_PART_DIV = 3;
  localparam logic [8:0] AEC_GAIN_ZERO_DB = 9'h000;

  typedef enum logic [1:0] {AEC_AUTO_OFF = 2'h0, AEC_AUTO_ONCE = 2'h1, AEC_AUTO_CONT = 2'h2} aec_auto_type;
  typedef enum logic [1:0] {AEC_LIGHT_NORM = 2'h0, AEC_LIGHT_BACK = 2'h1, AEC_LIGHT_FRONT = 2'h2} aec_light_type;
  typedef enum logic [1:0] {AEC_METER_AVG = 2'h0, AEC_METER_SPOT = 2'h1, AEC_METER_PART = 2'h2} aec_meter_type;
  typedef enum logic [1:0] {AEC_ST_IDLE = 2'b00, AEC_ST_CALC = 2'b01, AEC_ST_STEP = 2'b11} aec_state_type;
endpackage

// *** aec_regfile.sv ***
// Small register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module aec_regfile #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);
  logic [31:0] mem_q [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule
`default_nettype wire

// *** aec_ctrl.sv ***
// Auto exposure control loop with register port and pixel statistics
`timescale 1ns/1ps
`default_nettype none
module aec_ctrl import aec_pkg::*; #(
  parameter int DIM_W = 12,
  parameter int PIX_W = 8
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_frame_start,
  input wire logic i_pix_valid,
  input wire logic [DIM_W-1:0] i_pix_x,
  input wire logic [DIM_W-1:0] i_pix_y,
  input wire logic [PIX_W-1:0] i_pix,
  input wire logic [DIM_W-1:0] i_img_w,
  input wire logic [DIM_W-1:0] i_img_h,
  output logic [23:0] o_exp_us,
  output logic [7:0] o_gain_db,
  output logic o_update
);
  localparam int ACC_W = PIX_W + 2 * DIM_W;

  logic [31:0] ctrl_q;
  logic [23:0] exp_min_q, exp_max_q, prio_exp_q;
  logic [7:0] gain_min_q, gain_max_q;
  logic [6:0] tgt_q, tgt_min_q, tgt_max_q;
  logic [8:0] damp_q;
  logic signed [4:0] bias_q;
  logic [DIM_W-1:0] roi_x_q, roi_y_q, roi_w_q, roi_h_q;
  logic [23:0] exp_q;
  logic [7:0] gain_q;
  logic [ACC_W-1:0] sum_q, cnt_q;
  logic [PIX_W-1:0] meas_q;
  logic once_done_q;
  logic [31:0] mem_rdata, rd_mux_q;
  logic rd_reg_q;
  aec_state_type state_q;

  aec_auto_type exp_mode, gain_mode;
  aec_light_type light;
  aec_meter_type meter;
  logic exp_auto, gain_auto, active, prio_exp;

  assign exp_mode = aec_auto_type'(ctrl_q[AEC_F_EXPMODE +: 2]);
  assign gain_mode = aec_auto_type'(ctrl_q[AEC_F_GAINMODE +: 2]);
  assign light = aec_light_type'(ctrl_q[AEC_F_LIGHT +: 2]);
  assign meter = aec_meter_type'(ctrl_q[AEC_F_METER +: 2]);
  assign prio_exp = ctrl_q[AEC_F_PRIO];
  assign exp_auto = (exp_mode == AEC_AUTO_ONCE || exp_mode == AEC_AUTO_CONT) && !(exp_mode == AEC_AUTO_ONCE && once_done_q);
  assign gain_auto = (gain_mode == AEC_AUTO_ONCE || gain_mode == AEC_AUTO_CONT) && !(gain_mode == AEC_AUTO_ONCE && once_done_q);
  assign active = exp_auto || gain_auto;

  function automatic logic in_center(input logic [DIM_W-1:0] p, input logic [DIM_W-1:0] size, input int div);
    logic [DIM_W-1:0] half;
    logic [DIM_W-1:0] lo;
    half = DIM_W'(size / (2 * div));
    lo = DIM_W'((size >> 1) - half);
    in_center = (p >= lo) && (p < DIM_W'(lo + 2 * half));
  endfunction

  // Host register writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= AEC_CTRL_RST;
      exp_min_q <= AEC_EXP_MIN_RST;
      exp_max_q <= AEC_EXP_MAX_RST;
      gain_min_q <= AEC_GAIN_MIN_RST;
      gain_max_q <= AEC_GAIN_MAX_RST;
      tgt_q <= AEC_TGT_RST;
      tgt_min_q <= AEC_TGT_MIN_RST;
      tgt_max_q <= AEC_TGT_MAX_RST;
      damp_q <= AEC_DAMP_RST;
      prio_exp_q <= AEC_PRIO_EXP_RST;
      bias_q <= '0;
      roi_x_q <= '0;
      roi_y_q <= '0;
      roi_w_q <= '0;
      roi_h_q <= '0;
    end else if (i_wr) begin
      case (i_addr)
        AEC_REG_CTRL: ctrl_q <= i_wdata;
        AEC_REG_EXP_MIN: exp_min_q <= i_wdata[23:0];
        AEC_REG_EXP_MAX: exp_max_q <= i_wdata[23:0];
        AEC_REG_GAIN_MIN: gain_min_q <= i_wdata[7:0];
        AEC_REG_GAIN_MAX: gain_max_q <= i_wdata[7:0];
        AEC_REG_TGT: tgt_q <= (i_wdata[6:0] > AEC_PCT_FULL) ? AEC_PCT_FULL : i_wdata[6:0];
        AEC_REG_TGT_MIN: tgt_min_q <= i_wdata[6:0];
        AEC_REG_TGT_MAX: tgt_max_q <= i_wdata[6:0];
        AEC_REG_DAMP: damp_q <= (i_wdata[8:0] > AEC_DAMP_ONE) ? AEC_DAMP_ONE : i_wdata[8:0];
        AEC_REG_PRIO_EXP: prio_exp_q <= i_wdata[23:0];
        AEC_REG_BIAS: begin
          // Out-of-range bias saturates rather than wrapping to the other sign
          if ($signed(i_wdata[4:0]) > AEC_BIAS_MAX) begin
            bias_q <= AEC_BIAS_MAX;
          end else if ($signed(i_wdata[4:0]) < AEC_BIAS_MIN) begin
            bias_q <= AEC_BIAS_MIN;
          end else begin
            bias_q <= $signed(i_wdata[4:0]);
          end
        end
        AEC_REG_ROI_X: roi_x_q <= i_wdata[DIM_W-1:0];
        AEC_REG_ROI_Y: roi_y_q <= i_wdata[DIM_W-1:0];
        AEC_REG_ROI_W: roi_w_q <= i_wdata[DIM_W-1:0];
        AEC_REG_ROI_H: roi_h_q <= i_wdata[DIM_W-1:0];
        default: ;
      endcase
    end
  end

  // Shadow copy of written words; only the ROI words are read back from it, other mapped words come from the live registers, unmapped ones read zero
  aec_regfile #(.DEPTH(AEC_NREGS), .AW(5)) u_shadow (
    .i_clk(i_clk),
    .i_we(i_wr),
    .i_waddr(i_addr),
    .i_wdata(i_wdata),
    .i_raddr(i_addr),
    .o_rdata(mem_rdata)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_reg_q <= 1'b0;
      rd_mux_q <= '0;
    end else begin
      rd_reg_q <= 1'b0;
      rd_mux_q <= '0;
      if (i_rd) begin
        case (i_addr)
          AEC_REG_CTRL: rd_mux_q <= ctrl_q;
          AEC_REG_EXP_MIN: rd_mux_q <= {8'h00, exp_min_q};
          AEC_REG_EXP_MAX: rd_mux_q <= {8'h00, exp_max_q};
          AEC_REG_GAIN_MIN: rd_mux_q <= {24'h00_0000, gain_min_q};
          AEC_REG_GAIN_MAX: rd_mux_q <= {24'h00_0000, gain_max_q};
          AEC_REG_TGT: rd_mux_q <= {25'h000_0000, tgt_q};
          AEC_REG_TGT_MIN: rd_mux_q <= {25'h000_0000, tgt_min_q};
          AEC_REG_TGT_MAX: rd_mux_q <= {25'h000_0000, tgt_max_q};
          AEC_REG_DAMP: rd_mux_q <= {23'h00_0000, damp_q};
          AEC_REG_PRIO_EXP: rd_mux_q <= {8'h00, prio_exp_q};
          AEC_REG_BIAS: rd_mux_q <= {{27{bias_q[4]}}, bias_q};
          AEC_REG_EXP: rd_mux_q <= {8'h00, exp_q};
          AEC_REG_GAIN: rd_mux_q <= {24'h00_0000, gain_q};
          AEC_REG_MEAS: rd_mux_q <= 32'(meas_q);
          AEC_REG_STAT: rd_mux_q <= {29'h0000_0000, once_done_q, active, state_q != AEC_ST_IDLE};
          AEC_REG_ROI_X, AEC_REG_ROI_Y, AEC_REG_ROI_W, AEC_REG_ROI_H: rd_reg_q <= 1'b1;
          default: rd_mux_q <= '0;
        endcase
      end
    end
  end

  assign o_rdata = rd_reg_q ? (mem_rdata & 32'((1 << DIM_W) - 1)) : rd_mux_q;

  // Statistics window
  logic roi_on, in_win;
  logic [DIM_W-1:0] mx, my, mw, mh;
  always_comb begin
    roi_on = ctrl_q[AEC_F_ROIEN] && roi_w_q != '0 && roi_h_q != '0
             && DIM_W'(roi_x_q + roi_w_q) <= i_img_w && DIM_W'(roi_y_q + roi_h_q) <= i_img_h;
    mx = roi_on ? DIM_W'(i_pix_x - roi_x_q) : i_pix_x;
    my = roi_on ? DIM_W'(i_pix_y - roi_y_q) : i_pix_y;
    mw = roi_on ? roi_w_q : i_img_w;
    mh = roi_on ? roi_h_q : i_img_h;
    in_win = !roi_on || (i_pix_x >= roi_x_q && i_pix_y >= roi_y_q && mx < mw && my < mh);
    // Metering only applies under normal lighting; compensation modes meter the whole area
    if (light == AEC_LIGHT_NORM && meter == AEC_METER_SPOT) begin
      in_win = in_win && in_center(mx, mw, AEC_SPOT_DIV) && in_center(my, mh, AEC_SPOT_DIV);
    end else if (light == AEC_LIGHT_NORM && meter == AEC_METER_PART) begin
      in_win = in_win && in_center(mx, mw, AEC_PART_DIV) && in_center(my, mh, AEC_PART_DIV);
    end
  end

  // Per-frame accumulation, equal weight per pixel
  logic [ACC_W-1:0] fsum_q, fcnt_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fsum_q <= '0;
      fcnt_q <= '0;
      sum_q <= '0;
      cnt_q <= '0;
    end else if (i_frame_start) begin
      sum_q <= fsum_q;
      cnt_q <= fcnt_q;
      fsum_q <= '0;
      fcnt_q <= '0;
    end else if (i_pix_valid && in_win) begin
      fsum_q <= fsum_q + ACC_W'(i_pix);
      fcnt_q <= fcnt_q + 1'b1;
    end
  end

  // Target selection
  logic [7:0] tgt_base, tgt_biased, tgt_eff;
  logic signed [15:0] tgt_wide;
  logic [PIX_W+7:0] tgt_scaled;
  logic [PIX_W-1:0] tgt_pix;
  always_comb begin
    if (ctrl_q[AEC_F_TGTMAN]) begin
      tgt_base = {1'b0, tgt_q};
    end else begin
      case (light)
        AEC_LIGHT_BACK: tgt_base = {1'b0, AEC_TGT_AUTO_BACK};
        AEC_LIGHT_FRONT: tgt_base = {1'b0, AEC_TGT_AUTO_FRONT};
        default: tgt_base = (meter == AEC_METER_AVG) ? {1'b0, AEC_TGT_AUTO_NORM} : {1'b0, AEC_TGT_AUTO_SPOT};
      endcase
    end
    // Each third of a stop scales the target by roughly 2^(1/3); linearised as 1/4 per third
    // Worked out wide so a large bias saturates instead of wrapping
    tgt_wide = 16'($signed({1'b0, tgt_base})) + 16'($signed({1'b0, tgt_base})) * 16'(bias_q) / 16'sd4;
    if (tgt_wide < 0) begin
      tgt_biased = 8'h00;
    end else if (tgt_wide > $signed(16'(AEC_PCT_FULL))) begin
      tgt_biased = {1'b0, AEC_PCT_FULL};
    end else begin
      tgt_biased = tgt_wide[7:0];
    end
    tgt_eff = tgt_biased;
    if (tgt_eff < {1'b0, tgt_min_q}) tgt_eff = {1'b0, tgt_min_q};
    if (tgt_eff > {1'b0, tgt_max_q}) tgt_eff = {1'b0, tgt_max_q};
    tgt_scaled = (PIX_W + 8)'(tgt_eff) * (PIX_W + 8)'((1 << PIX_W) - 1);
    tgt_pix = PIX_W'(tgt_scaled / (PIX_W + 8)'(AEC_PCT_FULL));
  end

  // Loop state machine: measure, then step with damping
  logic signed [PIX_W+1:0] err;
  logic signed [PIX_W+10:0] step;
  logic [23:0] exp_lo, exp_hi;
  always_comb begin
    err = $signed({2'b00, tgt_pix}) - $signed({2'b00, meas_q});
    // Larger damping gives a smaller step, damping one freezes the loop
    step = (err * $signed({2'b00, AEC_DAMP_ONE - damp_q})) >>> 8;
    exp_lo = exp_min_q;
    exp_hi = exp_max_q;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= AEC_ST_IDLE;
      meas_q <= '0;
      exp_q <= AEC_PRIO_EXP_RST;
      gain_q <= AEC_GAIN_ZERO_DB[7:0];
      once_done_q <= 1'b0;
      o_update <= 1'b0;
      o_exp_us <= AEC_PRIO_EXP_RST;
      o_gain_db <= AEC_GAIN_ZERO_DB[7:0];
    end else begin
      o_update <= 1'b0;
      if (i_wr && i_addr == AEC_REG_CTRL) begin
        once_done_q <= 1'b0;
      end
      case (state_q)
        AEC_ST_IDLE: begin
          if (i_frame_start && active) begin
            state_q <= AEC_ST_CALC;
          end
        end
        AEC_ST_CALC: begin
          meas_q <= (cnt_q == '0) ? '0 : PIX_W'(sum_q / cnt_q);
          state_q <= AEC_ST_STEP;
        end
        AEC_ST_STEP: begin
          state_q <= AEC_ST_IDLE;
          if (exp_auto && gain_auto) begin
            if (!prio_exp) begin
              // Gain stays at 0 dB, or at gain_min_q if that is higher, unless exposure is pinned high and still too dark
              if (step > 0 && exp_q >= exp_hi || step < 0 && gain_q > gain_min_q && gain_q != 8'h00) begin
                gain_q <= clamp_g(gain_q, step);
              end else begin
                exp_q <= clamp_e(exp_q, step);
                gain_q <= clamp_g(AEC_GAIN_ZERO_DB[7:0], '0);
              end
            end else begin
              if (step > 0 && gain_q >= gain_max_q || step < 0 && exp_q > prio_exp_q) begin
                exp_q <= clamp_e(exp_q, step);
              end else begin
                gain_q <= clamp_g(gain_q, step);
                // Exposure sits at the programmed short time while gain does the work
                exp_q <= clamp_e(prio_exp_q, '0);
              end
            end
          end else if (exp_auto) begin
            exp_q <= clamp_e(exp_q, step);
          end else if (gain_auto) begin
            gain_q <= clamp_g(gain_q, step);
          end
          if (exp_mode == AEC_AUTO_ONCE || gain_mode == AEC_AUTO_ONCE) begin
            once_done_q <= (step == 0);
          end
        end
        default: state_q <= AEC_ST_IDLE;
      endcase
      // New values reach the sensor only on a frame boundary
      if (i_frame_start) begin
        o_exp_us <= exp_q;
        o_gain_db <= gain_q;
        o_update <= 1'b1;
      end
    end
  end

  function automatic logic [23:0] clamp_e(input logic [23:0] v, input logic signed [PIX_W+10:0] s);
    logic signed [25:0] n;
    n = $signed({2'b00, v}) + 26'(s <<< 4);
    if (n < $signed({2'b00, exp_min_q})) clamp_e = exp_min_q;
    else if (n > $signed({2'b00, exp_max_q})) clamp_e = exp_max_q;
    else clamp_e = n[23:0];
  endfunction

  function automatic logic [7:0] clamp_g(input logic [7:0] v, input logic signed [PIX_W+10:0] s);
    logic signed [PIX_W+11:0] n;
    n = $signed({{(PIX_W+4){1'b0}}, v}) + (PIX_W+12)'(s >>> 2);
    if (n < $signed({{(PIX_W+4){1'b0}}, gain_min_q})) clamp_g = gain_min_q;
    else if (n > $signed({{(PIX_W+4){1'b0}}, gain_max_q})) clamp_g = gain_max_q;
    else clamp_g = n[7:0];
  endfunction
endmodule
`default_nettype wire

// *** aec_ctrl_asserts.sv ***
// Port checker for the auto exposure controller
`timescale 1ns/1ps
`default_nettype none
module aec_ctrl_asserts import aec_pkg::*; (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_frame_start,
  input wire logic [23:0] o_exp_us,
  input wire logic [7:0] o_gain_db,
  input wire logic o_update
);
  logic [31:0] ctrl_q;
  logic [23:0] emin_q, emax_q, eprio_q;
  logic [7:0] gmin_q, gmax_q;
  logic [1:0] idle_q;
  logic run, both;
  assign run = (ctrl_q[1:0] != 2'h0) || (ctrl_q[3:2] != 2'h0);
  assign both = (ctrl_q[1:0] != 2'h0) && (ctrl_q[3:2] != 2'h0);
  // Shadow of host writes, so the limits are known from the ports alone
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= AEC_CTRL_RST;
      emin_q <= AEC_EXP_MIN_RST;
      emax_q <= AEC_EXP_MAX_RST;
      eprio_q <= AEC_PRIO_EXP_RST;
      gmin_q <= AEC_GAIN_MIN_RST;
      gmax_q <= AEC_GAIN_MAX_RST;
    end else if (i_wr) begin
      case (i_addr)
        AEC_REG_CTRL: ctrl_q <= i_wdata;
        AEC_REG_EXP_MIN: emin_q <= i_wdata[23:0];
        AEC_REG_EXP_MAX: emax_q <= i_wdata[23:0];
        AEC_REG_PRIO_EXP: eprio_q <= i_wdata[23:0];
        AEC_REG_GAIN_MIN: gmin_q <= i_wdata[7:0];
        AEC_REG_GAIN_MAX: gmax_q <= i_wdata[7:0];
        default: ;
      endcase
    end
  end
  // A step computed before the loop was stopped may still publish, so wait for frames
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) idle_q <= 2'h3;
    else if (i_wr && i_addr == AEC_REG_CTRL) idle_q <= 2'h0;
    else if (i_frame_start && !run && idle_q != 2'h3) idle_q <= idle_q + 2'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  upd_after_frame_a: assert property (i_frame_start |=> o_update)
    else $error("no update pulse after frame start");
  upd_only_frame_a: assert property (o_update |-> $past(i_frame_start))
    else $error("update pulse without frame start");
  out_at_boundary_a: assert property (($changed(o_exp_us) || $changed(o_gain_db)) |-> o_update)
    else $error("exposure or gain changed off the frame boundary");
  idle_hold_a: assert property (!run && idle_q == 2'h3 |-> $stable(o_exp_us) && $stable(o_gain_db))
    else $error("outputs moved with the loop off");
  exp_limits_a: assert property (run && $changed(o_exp_us) |-> o_exp_us >= emin_q && o_exp_us <= emax_q)
    else $error("exposure outside its limits");
  gain_limits_a: assert property (run && $changed(o_gain_db) |-> o_gain_db >= gmin_q && o_gain_db <= gmax_q)
    else $error("gain outside its limits");
  gain_prio_a: assert property (both && !ctrl_q[AEC_F_PRIO] && $changed(o_gain_db) |->
    o_gain_db == 8'h00 || o_exp_us == emax_q || $past(o_exp_us) == emax_q)
    else $error("gain moved before exposure reached maximum");
  exp_prio_a: assert property (both && ctrl_q[AEC_F_PRIO] && $changed(o_exp_us) |->
    o_exp_us == eprio_q || o_gain_db == gmax_q || $past(o_gain_db) == gmax_q)
    else $error("exposure moved before gain reached maximum");
  cover property (both && !ctrl_q[AEC_F_PRIO] && $changed(o_gain_db));
  cover property (both && ctrl_q[AEC_F_PRIO] && $changed(o_exp_us));
  cover property (!run && o_update);
endmodule
bind aec_ctrl aec_ctrl_asserts u_aec_ctrl_asserts (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_frame_start(i_frame_start), .o_exp_us(o_exp_us),
  .o_gain_db(o_gain_db), .o_update(o_update));
`default_nettype wire

// *** aec_sensor_model.sv ***
// Sensor and statistics path model: free-running frames of a two-zone scene
`timescale 1ns/1ps
`default_nettype none
module aec_sensor_model #(
  parameter int SIDE = 16,
  parameter int GAP = 8
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_core,
  input wire logic [7:0] i_rim,
  output logic o_frame_start,
  output logic o_pix_valid,
  output logic [11:0] o_pix_x,
  output logic [11:0] o_pix_y,
  output logic [7:0] o_pix,
  output logic [11:0] o_img_w,
  output logic [11:0] o_img_h
);
  localparam int LAST = SIDE * SIDE + GAP - 1;
  int cnt_q;
  logic [11:0] x, y;
  logic inner;
  assign x = 12'(cnt_q % SIDE);
  assign y = 12'(cnt_q / SIDE);
  assign inner = x >= 12'(SIDE / 4) && x < 12'(3 * SIDE / 4) && y >= 12'(SIDE / 4) && y < 12'(3 * SIDE / 4);
  assign o_img_w = 12'(SIDE);
  assign o_img_h = 12'(SIDE);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 0;
      o_frame_start <= 1'b0;
      o_pix_valid <= 1'b0;
      o_pix_x <= 12'h000;
      o_pix_y <= 12'h000;
      o_pix <= 8'h00;
    end else begin
      cnt_q <= (cnt_q == LAST) ? 0 : cnt_q + 1;
      o_frame_start <= (cnt_q == LAST);
      o_pix_valid <= (cnt_q < SIDE * SIDE);
      o_pix_x <= x;
      o_pix_y <= y;
      // Blanking toggles the pixel bus so stale data never looks valid
      o_pix <= (cnt_q < SIDE * SIDE) ? (inner ? i_core : i_rim) : ~o_pix;
    end
  end
endmodule
`default_nettype wire

// *** aec_ctrl_tb.sv ***
// Self-checking bench for the auto exposure controller
`timescale 1ns/1ps
`default_nettype none
module aec_ctrl_tb import aec_pkg::*; ;
  logic i_clk, i_arst_n, i_wr, i_rd, i_frame_start, i_pix_valid, o_update;
  logic [4:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rnd, got, m0, m1;
  logic [11:0] i_pix_x, i_pix_y, i_img_w, i_img_h;
  logic [7:0] i_pix, o_gain_db, core, rim;
  logic [23:0] o_exp_us;
  int n_mismatch, total_checks;
  logic [4:0] ra [12] = '{AEC_REG_CTRL, AEC_REG_EXP_MIN, AEC_REG_EXP_MAX, AEC_REG_GAIN_MIN, AEC_REG_GAIN_MAX,
    AEC_REG_TGT, AEC_REG_TGT_MIN, AEC_REG_TGT_MAX, AEC_REG_DAMP, AEC_REG_PRIO_EXP, AEC_REG_BIAS, 5'h1f};
  logic [31:0] rv [12] = '{32'h0, 32'h1, 32'hff_ffff, 32'h0, 32'hff, 32'h32, 32'h0, 32'h64, 32'h80, 32'h1388,
    32'h0, 32'h0};
  aec_ctrl u_aec_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_frame_start(i_frame_start), .i_pix_valid(i_pix_valid),
    .i_pix_x(i_pix_x), .i_pix_y(i_pix_y), .i_pix(i_pix), .i_img_w(i_img_w), .i_img_h(i_img_h),
    .o_exp_us(o_exp_us), .o_gain_db(o_gain_db), .o_update(o_update));
  aec_sensor_model u_aec_sensor_model (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_core(core), .i_rim(rim),
    .o_frame_start(i_frame_start), .o_pix_valid(i_pix_valid), .o_pix_x(i_pix_x), .o_pix_y(i_pix_y),
    .o_pix(i_pix), .o_img_w(i_img_w), .o_img_h(i_img_h));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] bias_exp(input int v);
    return 32'(v < -9 ? -9 : (v > 9 ? 9 : v));
  endfunction
  function automatic logic [31:0] damp_exp(input logic [8:0] d);
    return (d > 9'h100) ? 32'h100 : {23'h0, d};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rst();
    i_arst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
  endtask
  task automatic wait_fs(input int n);
    repeat (n) begin
      @(posedge i_clk);
      while (i_frame_start !== 1'b1) @(posedge i_clk);
    end
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic measure(input logic [7:0] c, input logic [7:0] r, output logic [31:0] m);
    core <= c;
    rim <= r;
    wait_fs(2);
    rd(AEC_REG_MEAS, m);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 5'h00;
    i_wdata = 32'h0;
    core = 8'h04;
    rim = 8'h04;
    rnd = 32'h40eb6a88;
    rst();
    #1;
    check({o_exp_us, o_gain_db}, 32'h0013_8800);
    wr(5'h1f, 32'hffff_ffff);
    for (int i = 0; i < 12; i++) begin
      rd(ra[i], got);
      check(got, rv[i]);
    end
    wr(AEC_REG_BIAS, 32'hffff_fff0);
    rd(AEC_REG_BIAS, got);
    check(got, 32'hffff_fff7);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr(AEC_REG_EXP_MAX, {8'h00, rnd[23:0]});
      rd(AEC_REG_EXP_MAX, got);
      check(got, {8'h00, rnd[23:0]});
      wr(AEC_REG_BIAS, 32'($signed(rnd[28:24])));
      rd(AEC_REG_BIAS, got);
      check(got, bias_exp($signed(rnd[28:24])));
      wr(AEC_REG_DAMP, {22'h0, rnd[9:0]});
      rd(AEC_REG_DAMP, got);
      check(got, damp_exp(rnd[8:0]));
    end
    // Loop off: a dark scene must not move anything
    wait_fs(3);
    check({o_exp_us, o_gain_db}, 32'h0013_8800);
    for (int p = 0; p < 2; p++) begin
      rst();
      wr(AEC_REG_EXP_MAX, 32'h1770);
      wr(AEC_REG_GAIN_MAX, 32'h0c);
      wr(AEC_REG_PRIO_EXP, 32'hfa0);
      wr(AEC_REG_DAMP, 32'h0);
      wr(AEC_REG_CTRL, 32'h0a | 32'(p << AEC_F_PRIO));
      for (int f = 0; f < 20 && (p == 1 ? o_gain_db == 8'h00 : o_exp_us == 24'h1388); f++) wait_fs(1);
      if (p == 0) check(32'(o_gain_db == 8'h00 && o_exp_us > 24'h1388), 32'h1);
      else check({8'h00, o_exp_us}, 32'hfa0);
      wait_fs(50);
      check({o_gain_db, o_exp_us}, 32'h0c00_1770);
    end
    rst();
    core <= 8'hff;
    rim <= 8'hff;
    wr(AEC_REG_EXP_MIN, 32'h3e8);
    wr(AEC_REG_CTRL, 32'h01);
    wait_fs(50);
    check({o_gain_db, o_exp_us}, 32'h0000_03e8);
    // Pass 3 asks for spot metering under backlight, which must fall back to the whole area
    for (int m = 0; m < 4; m++) begin
      wr(AEC_REG_CTRL, 32'h02 | (32'(m == 3 ? 1 : m) << AEC_F_METER) | (32'(m == 3) << AEC_F_LIGHT));
      measure(8'h64, 8'h00, m0);
      measure(8'h64, 8'hff, m1);
      if (m == 0 || m == 3) begin
        check(m0, 32'h19);
        check(m1, 32'hd8);
      end else begin
        check(m1, m0);
        check(m0, 32'h64);
      end
    end
    wr(AEC_REG_CTRL, 32'h02 | 32'(1 << AEC_F_ROIEN));
    wr(AEC_REG_ROI_X, 32'h0);
    wr(AEC_REG_ROI_Y, 32'h0);
    wr(AEC_REG_ROI_W, 32'h4);
    wr(AEC_REG_ROI_H, 32'h4);
    measure(8'h00, 8'h50, m0);
    measure(8'hff, 8'h50, m1);
    check(m1, m0);
    check(m0, 32'h50);
    complete_run();
  end
endmodule
`default_nettype wire
